/* hdl/kprc_count_decode.sv */
`timescale 1ns/1ps
module kprc_count_decode #(
    parameter int unsigned N = 8
) (
    input wire logic [3:0] count,
    output logic [N-1:0] enable
);
    // bit 3 set means every line; otherwise lines 0..count-1 in the array
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_line
            assign enable[i] = count[kprc_pkg::ALL_BIT] || (32'(count) > i);
        end
    endgenerate
endmodule : kprc_count_decode

/* hdl/kprc_top.sv */
`timescale 1ns/1ps
module kprc_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic addr_hit,
    output kprc_pkg::kprc_role_t row_role,
    output kprc_pkg::kprc_role_t col_role
);
    logic [7:0] key_array_extent;
    logic [7:0] led_output_select;
    logic [7:0] row_line_direction;
    logic [7:0] column_line_direction;
    logic [7:0] row_line_output_style;
    logic [7:0] column_line_output_style;
    kprc_pkg::kprc_req_t req;

    assign req = '{wr: wr, addr: addr, wdata: wdata};

    wire sel_extent = req.addr == kprc_pkg::ADDR_EXTENT;
    wire sel_led = req.addr == kprc_pkg::ADDR_LED_SEL;
    wire sel_rdir = req.addr == kprc_pkg::ADDR_ROW_DIR;
    wire sel_cdir = req.addr == kprc_pkg::ADDR_COL_DIR;
    wire sel_rsty = req.addr == kprc_pkg::ADDR_ROW_STYLE;
    wire sel_csty = req.addr == kprc_pkg::ADDR_COL_STYLE;
    wire we = ce && req.wr;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            key_array_extent <= kprc_pkg::RST_EXTENT;
            led_output_select <= kprc_pkg::RST_LED_SEL;
            row_line_direction <= kprc_pkg::RST_DIR;
            column_line_direction <= kprc_pkg::RST_DIR;
            row_line_output_style <= kprc_pkg::RST_ROW_STYLE;
            column_line_output_style <= kprc_pkg::RST_COL_STYLE;
        end else if (we) begin
            if (sel_extent) key_array_extent <= req.wdata;
            if (sel_led) led_output_select <= req.wdata & kprc_pkg::MASK_LED_SEL;
            if (sel_rdir) row_line_direction <= req.wdata;
            if (sel_cdir) column_line_direction <= req.wdata;
            if (sel_rsty) row_line_output_style <= req.wdata;
            // upper style bits are not writable
            if (sel_csty) begin
                column_line_output_style <= req.wdata & kprc_pkg::MASK_COL_STYLE;
            end
        end
    end

    assign addr_hit = sel_extent | sel_led | sel_rdir | sel_cdir | sel_rsty | sel_csty;

    // read data registered so it is glitch-free toward the serial shifter
    wire [7:0] next_rdata = sel_extent ? key_array_extent :
                            sel_led ? led_output_select :
                            sel_rdir ? row_line_direction :
                            sel_cdir ? column_line_direction :
                            sel_rsty ? row_line_output_style :
                            sel_csty ? column_line_output_style : 8'h00;

    always_ff @(posedge mclk) begin
        if (!rstn) rdata <= 8'h00;
        else if (ce) rdata <= next_rdata;
    end

    logic [7:0] row_key;
    logic [7:0] col_key;

    kprc_count_decode #(.N(kprc_pkg::LINES)) u_row_dec (
        .count(key_array_extent[kprc_pkg::ROW_CNT_LSB +: 4]),
        .enable(row_key)
    );
    kprc_count_decode #(.N(kprc_pkg::LINES)) u_col_dec (
        .count(key_array_extent[kprc_pkg::ROW_CNT_LSB-1:0]),
        .enable(col_key)
    );

    wire [7:0] col_led = {led_output_select[3:0], 4'h0};

    assign row_role.key = row_key;
    assign row_role.led = 8'h00;
    assign row_role.gpio_out = ~row_key & row_line_direction;
    assign row_role.push_pull = row_line_output_style;
    assign col_role.key = col_key;
    assign col_role.led = col_led & ~col_key;
    assign col_role.gpio_out = ~col_key & ~col_led & column_line_direction;
    assign col_role.push_pull = column_line_output_style;

    AST_ROWS_ALL: assert property (@(posedge mclk) disable iff (!rstn)
        key_array_extent[7] |-> row_role.key == 8'hff) else $error("rows not all keys");
    AST_ROWS_NONE: assert property (@(posedge mclk) disable iff (!rstn)
        key_array_extent[7:4] == 4'h0 |-> row_role.key == 8'h00) else $error("rows present");
    AST_COLS_ALL: assert property (@(posedge mclk) disable iff (!rstn)
        key_array_extent[3] |-> col_role.key == 8'hff) else $error("cols not all keys");
    AST_COLS_NONE: assert property (@(posedge mclk) disable iff (!rstn)
        key_array_extent[3:0] == 4'h0 |-> col_role.key == 8'h00) else $error("cols present");
    AST_RESET_VAL: assert property (@(posedge mclk)
        !rstn |=> key_array_extent == kprc_pkg::RST_EXTENT
            && column_line_output_style == kprc_pkg::RST_COL_STYLE)
        else $error("bad reset values");
    AST_RESET_LED: assert property (@(posedge mclk)
        !rstn |=> led_output_select == kprc_pkg::RST_LED_SEL)
        else $error("led select not reset");
    AST_RESET_DIR: assert property (@(posedge mclk)
        !rstn |=> row_line_direction == kprc_pkg::RST_DIR
            && column_line_direction == kprc_pkg::RST_DIR)
        else $error("directions not reset");
    AST_RESET_STYLE: assert property (@(posedge mclk)
        !rstn |=> row_line_output_style == kprc_pkg::RST_ROW_STYLE && rdata == 8'h00)
        else $error("row style or read data not reset");
    AST_EXTENT_WR: assert property (@(posedge mclk) disable iff (!rstn)
        we && sel_extent |=> key_array_extent == $past(wdata)) else $error("extent lost");
    AST_LED_UPPER: assert property (@(posedge mclk) disable iff (!rstn)
        led_output_select[7:4] == 4'h0) else $error("led reserved bits set");
    AST_LED_WR: assert property (@(posedge mclk) disable iff (!rstn)
        we && sel_led |=> led_output_select == ($past(wdata) & kprc_pkg::MASK_LED_SEL))
        else $error("led select lost");
    AST_ROW_NO_LED: assert property (@(posedge mclk) disable iff (!rstn)
        row_role.led == 8'h00) else $error("row line as led");
    AST_ROW_DIR_WR: assert property (@(posedge mclk) disable iff (!rstn)
        we && sel_rdir |=> row_line_direction == $past(wdata)) else $error("row dir lost");
    AST_COL_DIR_WR: assert property (@(posedge mclk) disable iff (!rstn)
        we && sel_cdir |=> column_line_direction == $past(wdata)) else $error("col dir lost");
    AST_ROW_STY_WR: assert property (@(posedge mclk) disable iff (!rstn)
        we && sel_rsty |=> row_role.push_pull == $past(wdata)) else $error("row style lost");
    AST_COL_OD: assert property (@(posedge mclk) disable iff (!rstn)
        col_role.push_pull[7:4] == 4'h0) else $error("upper column push-pull");
    AST_COL_STY_KEEP: assert property (@(posedge mclk) disable iff (!rstn)
        we && sel_csty |=> column_line_output_style == ($past(wdata) & kprc_pkg::MASK_COL_STYLE))
        else $error("col style write");
    AST_GPIO_ROLE: assert property (@(posedge mclk) disable iff (!rstn)
        (col_role.gpio_out & (col_role.key | col_role.led)) == 8'h00)
        else $error("gpio overlaps role");
    AST_LED_KEY: assert property (@(posedge mclk) disable iff (!rstn)
        (col_role.led & col_role.key) == 8'h00) else $error("led overlaps key");
    AST_FREEZE: assert property (@(posedge mclk) disable iff (!rstn) // ce low holds state
        !ce |=> $stable(key_array_extent) && $stable(led_output_select)
            && $stable(row_line_direction) && $stable(column_line_direction)
            && $stable(row_line_output_style) && $stable(column_line_output_style)
            && $stable(rdata))
        else $error("state moved with ce low");
    AST_UNMAPPED_WR: assert property (@(posedge mclk) disable iff (!rstn) // stray writes dropped
        we && !addr_hit |=> $stable(key_array_extent) && $stable(led_output_select)
            && $stable(row_line_direction) && $stable(column_line_direction)
            && $stable(row_line_output_style) && $stable(column_line_output_style))
        else $error("unmapped write landed");
    AST_RDATA_UNMAPPED: assert property (@(posedge mclk) disable iff (!rstn) // empty reads zero
        ce && !addr_hit |=> rdata == 8'h00) else $error("unmapped read not zero");

    // per-line view of the array decode and of the pin roles
    genvar k;
    generate
        for (k = 0; k < kprc_pkg::LINES; k++) begin : g_line_chk
            AST_ROW_LINE_ON: assert property (@(posedge mclk) disable iff (!rstn)
                key_array_extent[7] || key_array_extent[6:4] > 3'(k) |-> row_role.key[k])
                else $error("row line missing from array");
            AST_ROW_LINE_OFF: assert property (@(posedge mclk) disable iff (!rstn)
                !key_array_extent[7] && key_array_extent[6:4] <= 3'(k) |-> !row_role.key[k])
                else $error("row line wrongly in array");
            AST_COL_LINE_ON: assert property (@(posedge mclk) disable iff (!rstn)
                key_array_extent[3] || key_array_extent[2:0] > 3'(k) |-> col_role.key[k])
                else $error("column line missing from array");
            AST_COL_LINE_OFF: assert property (@(posedge mclk) disable iff (!rstn)
                !key_array_extent[3] && key_array_extent[2:0] <= 3'(k) |-> !col_role.key[k])
                else $error("column line wrongly in array");
            AST_ROW_GPIO_LINE: assert property (@(posedge mclk) disable iff (!rstn)
                row_role.gpio_out[k] == (row_line_direction[k] && !row_role.key[k]))
                else $error("row line gpio role wrong");
            AST_COL_GPIO_LINE: assert property (@(posedge mclk) disable iff (!rstn)
                col_role.gpio_out[k]
                    == (column_line_direction[k] && !col_role.key[k] && !col_role.led[k]))
                else $error("column line gpio role wrong");
        end
    endgenerate

    COV_SMALL_ARRAY: cover property (@(posedge mclk) disable iff (!rstn)
        we && sel_extent && wdata == 8'h34);
    COV_LED_ON: cover property (@(posedge mclk) disable iff (!rstn) col_role.led != 8'h00);
    COV_ROW_OUT: cover property (@(posedge mclk) disable iff (!rstn) row_role.gpio_out != 8'h00);
    COV_FROZEN_WR: cover property (@(posedge mclk) disable iff (!rstn) !ce && wr);
    COV_STRAY_WR: cover property (@(posedge mclk) disable iff (!rstn) we && !addr_hit);
endmodule : kprc_top

/* shared/kprc_pkg.sv */
package kprc_pkg;
    localparam int unsigned LINES = 8;
    localparam logic [7:0] ADDR_EXTENT = 8'h30;
    localparam logic [7:0] ADDR_LED_SEL = 8'h31;
    localparam logic [7:0] ADDR_ROW_DIR = 8'h34;
    localparam logic [7:0] ADDR_COL_DIR = 8'h35;
    localparam logic [7:0] ADDR_ROW_STYLE = 8'h36;
    localparam logic [7:0] ADDR_COL_STYLE = 8'h37;
    localparam logic [7:0] RST_EXTENT = 8'hff;
    localparam logic [7:0] RST_LED_SEL = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_ROW_STYLE = 8'hff;
    localparam logic [7:0] RST_COL_STYLE = 8'h0f;
    localparam logic [7:0] MASK_LED_SEL = 8'h0f;
    localparam logic [7:0] MASK_COL_STYLE = 8'h0f;
    localparam int unsigned ROW_CNT_LSB = 4;
    localparam int unsigned ALL_BIT = 3;
    localparam int unsigned UPPER_COL = 4;

    // per-line role as seen by the pad logic
    typedef struct packed {
        logic [7:0] key;
        logic [7:0] led;
        logic [7:0] gpio_out;
        logic [7:0] push_pull;
    } kprc_role_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } kprc_req_t;
endpackage : kprc_pkg

/* test/kprc_host.sv */
`timescale 1ns/1ps
module kprc_host (
    input wire logic mclk,
    output logic ce,
    output logic wr,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    initial begin
        ce = 1'b1;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // called at a falling edge; one write strobe then one idle cycle per call
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
        wdata = ~d; // stale data inverted so a late capture shows up
        @(negedge mclk);
    endtask : put
    // write strobe with the clock enable low must change nothing
    task automatic hold(input logic [7:0] a, input logic [7:0] d);
        ce = 1'b0;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        ce = 1'b1;
        wr = 1'b0;
        @(negedge mclk);
    endtask : hold
    task automatic aim(input logic [7:0] a);
        addr = a;
        @(negedge mclk);
    endtask : aim
endmodule : kprc_host

/* test/kprc_top_bench.sv */
`timescale 1ns/1ps
module kprc_top_bench;
    logic mclk;
    logic rstn;
    logic ce;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic addr_hit;
    kprc_pkg::kprc_role_t row_role;
    kprc_pkg::kprc_role_t col_role;
    logic [7:0] exp_cnt;
    int err_count = 0;
    int n_tests = 0;
    kprc_host u_host (.mclk(mclk), .ce(ce), .wr(wr), .addr(addr), .wdata(wdata));
    kprc_top u_dut (.mclk(mclk), .rstn(rstn), .ce(ce), .wr(wr), .addr(addr), .wdata(wdata),
        .rdata(rdata), .addr_hit(addr_hit), .row_role(row_role), .col_role(col_role));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_host.aim(a);
        chk(rdata, exp);
    endtask : rd
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    // whole sequence needs about 75 cycles; the limit allows over thirty times that
    initial begin
        #200us;
        err_count++;
        final_report();
    end
    initial begin
        rstn = 1'b0;
        repeat (10) @(negedge mclk);
        rstn = 1'b1;
        chk(row_role.key, 8'hff);
        rd(kprc_pkg::ADDR_EXTENT, kprc_pkg::RST_EXTENT);
        rd(kprc_pkg::ADDR_LED_SEL, kprc_pkg::RST_LED_SEL);
        rd(kprc_pkg::ADDR_ROW_DIR, kprc_pkg::RST_DIR);
        rd(kprc_pkg::ADDR_COL_DIR, kprc_pkg::RST_DIR);
        rd(kprc_pkg::ADDR_ROW_STYLE, kprc_pkg::RST_ROW_STYLE);
        rd(kprc_pkg::ADDR_COL_STYLE, kprc_pkg::RST_COL_STYLE);
        for (int n = 0; n < 16; n++) begin
            exp_cnt = n[3] ? 8'hff : 8'((1 << n) - 1);
            u_host.put(kprc_pkg::ADDR_EXTENT, {n[3:0], n[3:0]});
            chk(row_role.key, exp_cnt);
            chk(col_role.key, exp_cnt);
        end
        u_host.put(kprc_pkg::ADDR_EXTENT, 8'h34);
        u_host.put(kprc_pkg::ADDR_LED_SEL, 8'hff);
        rd(kprc_pkg::ADDR_LED_SEL, 8'h0f);
        chk(col_role.led, 8'hf0);
        u_host.put(kprc_pkg::ADDR_COL_STYLE, 8'hff);
        rd(kprc_pkg::ADDR_COL_STYLE, 8'h0f);
        chk(col_role.push_pull, 8'h0f);
        u_host.put(kprc_pkg::ADDR_ROW_STYLE, 8'h5a);
        chk(row_role.push_pull, 8'h5a);
        u_host.put(kprc_pkg::ADDR_ROW_DIR, 8'hff);
        chk(row_role.gpio_out, 8'hf8);
        u_host.put(kprc_pkg::ADDR_LED_SEL, 8'h01);
        u_host.put(kprc_pkg::ADDR_COL_DIR, 8'hff);
        chk(col_role.gpio_out, 8'he0);
        chk(col_role.led, 8'h10);
        u_host.hold(kprc_pkg::ADDR_ROW_DIR, 8'h00);
        rd(kprc_pkg::ADDR_ROW_DIR, 8'hff);
        chk(row_role.gpio_out, 8'hf8);
        u_host.put(8'h32, 8'h00);
        rd(kprc_pkg::ADDR_COL_DIR, 8'hff);
        rd(8'h32, 8'h00);
        chk({7'h00, addr_hit}, 8'h00);
        rstn = 1'b0;
        @(negedge mclk);
        rstn = 1'b1;
        rd(kprc_pkg::ADDR_ROW_STYLE, kprc_pkg::RST_ROW_STYLE);
        rd(kprc_pkg::ADDR_LED_SEL, kprc_pkg::RST_LED_SEL);
        chk(col_role.key, 8'hff);
        chk(row_role.gpio_out, 8'h00);
        final_report();
    end
endmodule : kprc_top_bench
